// [logic/fpim_pkg.sv]
package fpim_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CUTOFF_HZ_DEF = 50;
  localparam int unsigned QUALIFY_MS_DEF = 250;
  localparam int unsigned QUALIFY_CYC_DEF = QUALIFY_MS_DEF * (CLK_HZ / 1000);
  // one-millisecond tick and one-second rate gate
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  localparam int unsigned SEC_CYC = CLK_HZ;

  // ----------------------------------------------------------------------
  // integrity batch
  // ----------------------------------------------------------------------
  localparam int unsigned BATCH_PULSES = 1000;
  localparam logic [7:0] ERR_THRESH_DEF = 8'h03;

  localparam int unsigned RATE_W = 24;
  localparam int unsigned LPM_PER_HZ = 60;

  typedef struct packed {
    logic quadEnable;
    logic [15:0] cutoffHz;
    logic [7:0] errThresh;
    logic [15:0] additivePulsesPerL;
    logic [15:0] wildPulsesPerL;
  } fpim_cfg_t;

  typedef struct packed {
    logic [RATE_W-1:0] additiveLpm;
    logic [RATE_W-1:0] wildLpm;
    logic [31:0] additiveCount;
    logic [31:0] wildCount;
  } fpim_flow_t;

  typedef struct packed {
    logic hwError;
    logic belowCutoff;
    logic [7:0] batchErrors;
    logic [9:0] batchPulses;
  } fpim_check_t;

endpackage : fpim_pkg

// [logic/fpim_input_qualify.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// digital input qualifier: sync then stable-time filter
// ----------------------------------------------------------------------
module fpim_input_qualify #(
  parameter int unsigned QUALIFY_CYC = fpim_pkg::QUALIFY_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rawIn,
  output logic qualified
);
  localparam int unsigned CW = $clog2(QUALIFY_CYC + 1);
  logic sync1_q, sync2_q, qual_q, qual_d;
  logic [CW-1:0] cnt_q, cnt_d;

  always_comb begin
    qual_d = qual_q;
    cnt_d = cnt_q;
    if (sync2_q == qual_q) begin
      cnt_d = '0;
    end else if (cnt_q >= CW'(QUALIFY_CYC - 1)) begin
      // level held long enough, accept it
      qual_d = sync2_q;
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      qual_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
      qual_q <= qual_d;
      cnt_q <= cnt_d;
    end
  end

  assign qualified = qual_q;
endmodule : fpim_input_qualify

// [logic/fpim_monitor.sv]
`timescale 1ns/10ps
// Operation
// - setting selects single pulse or quadrature
// - no integrity checks below cut-off frequency (missing and phase pulses still flag below it, they are just not counted)
// - too many errors per 1000 raises error
// - missing pulses under cut-off are ignored
// - phase error counts like a missing pulse
// - additive on channel A, wild separately
// - both flow rates in litres per minute
// - input valid after stable qualify time
module fpim_monitor #(
  parameter int unsigned DI_COUNT = 4,
  parameter int unsigned QUALIFY_CYC = fpim_pkg::QUALIFY_CYC_DEF,
  parameter int unsigned SEC_CYC = fpim_pkg::SEC_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire fpim_pkg::fpim_cfg_t cfg,
  input wire logic quadA,
  input wire logic quadB,
  input wire logic wildPulse,
  input wire logic [DI_COUNT-1:0] digitalInput,
  output fpim_pkg::fpim_flow_t flow,
  output fpim_pkg::fpim_check_t check,
  output logic [DI_COUNT-1:0] digitalQualified,
  output logic phaseErrPulse,
  output logic missingPulse
);
  localparam int unsigned SW = $clog2(SEC_CYC + 1);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] s1_q, s2_q, s3_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {wildPulse, quadB, quadA};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // channel A always carries additive, even single-pulse meters
  logic riseA, riseB, riseW;
  assign riseA = s2_q[0] & ~s3_q[0];
  assign riseB = s2_q[1] & ~s3_q[1];
  assign riseW = s2_q[2] & ~s3_q[2];

  // ----------------------------------------------------------------------
  // one-second gate: pulse counts and frequencies
  // ----------------------------------------------------------------------
  logic [SW-1:0] sec_q, sec_d;
  logic [15:0] aHz_q, aHz_d, wHz_q, wHz_d, aFreq_q, aFreq_d;
  logic [15:0] wFreq_q, wFreq_d;
  logic [31:0] aTot_q, aTot_d, wTot_q, wTot_d;
  logic [fpim_pkg::RATE_W-1:0] aLpm_q, aLpm_d, wLpm_q, wLpm_d;
  logic secTick;
  assign secTick = (sec_q == SW'(SEC_CYC - 1));

  // litres per minute = Hz * 60 / pulses per litre
  function automatic logic [fpim_pkg::RATE_W-1:0] toLpm(
    input logic [15:0] hz,
    input logic [15:0] ppl
  );
    logic [31:0] prod;
    prod = 32'(hz) * 32'(fpim_pkg::LPM_PER_HZ);
    if (ppl == 16'h0000) begin
      toLpm = '0;
    end else begin
      toLpm = fpim_pkg::RATE_W'(prod / 32'(ppl));
    end
  endfunction : toLpm

  always_comb begin
    sec_d = secTick ? '0 : sec_q + SW'(1);
    aHz_d = aHz_q + 16'(riseA);
    wHz_d = wHz_q + 16'(riseW);
    aFreq_d = aFreq_q;
    wFreq_d = wFreq_q;
    aLpm_d = aLpm_q;
    wLpm_d = wLpm_q;
    aTot_d = aTot_q + 32'(riseA);
    wTot_d = wTot_q + 32'(riseW);
    if (secTick) begin
      aFreq_d = aHz_d;
      wFreq_d = wHz_d;
      aLpm_d = toLpm(aHz_d, cfg.additivePulsesPerL);
      wLpm_d = toLpm(wHz_d, cfg.wildPulsesPerL);
      aHz_d = '0;
      wHz_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sec_q <= '0;
      aHz_q <= '0;
      wHz_q <= '0;
      aFreq_q <= '0;
      wFreq_q <= '0;
      aLpm_q <= '0;
      wLpm_q <= '0;
      aTot_q <= '0;
      wTot_q <= '0;
    end else begin
      sec_q <= sec_d;
      aHz_q <= aHz_d;
      wHz_q <= wHz_d;
      aFreq_q <= aFreq_d;
      wFreq_q <= wFreq_d;
      aLpm_q <= aLpm_d;
      wLpm_q <= wLpm_d;
      aTot_q <= aTot_d;
      wTot_q <= wTot_d;
    end
  end

  // ----------------------------------------------------------------------
  // quadrature integrity: A and B edges must alternate
  // ----------------------------------------------------------------------
  // expectB: last edge seen on A, next must be B
  logic expB_q, expB_d, phErr_d, miss_d, phErr_q, miss_q;
  logic [9:0] bPul_q, bPul_d;
  logic [7:0] bErr_q, bErr_d;
  logic hwErr_q, hwErr_d, below;
  // frequency lags one second, so the first second counts as below
  assign below = (aFreq_q < cfg.cutoffHz);

  always_comb begin
    expB_d = expB_q;
    phErr_d = 1'b0;
    miss_d = 1'b0;
    bPul_d = bPul_q;
    bErr_d = bErr_q;
    hwErr_d = hwErr_q;
    if (!cfg.quadEnable) begin
      // single-pulse mode: no checking at all
      expB_d = 1'b0;
      bPul_d = '0;
      bErr_d = '0;
      hwErr_d = 1'b0;
    end else begin
      if (riseA && riseB) begin
        // simultaneous edges: order unknown
        phErr_d = 1'b1;
        expB_d = 1'b0;
      end else if (riseA) begin
        // second A without B means B edge absent
        miss_d = expB_q;
        expB_d = 1'b1;
      end else if (riseB) begin
        // B with no A before it is out of order
        phErr_d = ~expB_q;
        expB_d = 1'b0;
      end
      // errors under cut-off are dropped
      if ((phErr_d || miss_d) && !below) begin
        bErr_d = (bErr_q == 8'hff) ? bErr_q : bErr_q + 8'h01;
      end
      if (bErr_d > cfg.errThresh) begin
        hwErr_d = 1'b1;
      end
      if (riseA) begin
        if (bPul_q == 10'(fpim_pkg::BATCH_PULSES - 1)) begin
          bPul_d = '0;
          bErr_d = '0;
        end else begin
          bPul_d = bPul_q + 10'h001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      expB_q <= 1'b0;
      phErr_q <= 1'b0;
      miss_q <= 1'b0;
      bPul_q <= '0;
      bErr_q <= '0;
      hwErr_q <= 1'b0;
    end else begin
      expB_q <= expB_d;
      phErr_q <= phErr_d;
      miss_q <= miss_d;
      bPul_q <= bPul_d;
      bErr_q <= bErr_d;
      hwErr_q <= hwErr_d;
    end
  end

  // ----------------------------------------------------------------------
  // digital inputs
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < DI_COUNT; i++) begin : g_di
    fpim_input_qualify #(
      .QUALIFY_CYC(QUALIFY_CYC)
    ) u_qual (
      .clk(clk),
      .rst(rst),
      .rawIn(digitalInput[i]),
      .qualified(digitalQualified[i])
    );
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  logic belowR_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      belowR_q <= 1'b1;
    end else begin
      belowR_q <= below;
    end
  end

  // one driver per struct port, members all straight from flip-flops
  assign flow = '{
    additiveLpm: aLpm_q,
    wildLpm: wLpm_q,
    additiveCount: aTot_q,
    wildCount: wTot_q
  };
  assign check = '{
    hwError: hwErr_q,
    belowCutoff: belowR_q,
    batchErrors: bErr_q,
    batchPulses: bPul_q
  };
  assign phaseErrPulse = phErr_q;
  assign missingPulse = miss_q;
endmodule : fpim_monitor

// [dv/fpim_meter_model.sv]
`timescale 1ns/10ps
// ------------
// flow meters
// ------------
module fpim_meter_model (
  input wire logic clk,
  input wire logic run,
  input wire logic dropA,
  input wire logic dropB,
  output logic quadA,
  output logic quadB,
  output logic wildPulse
);
  logic [2:0] phase_q = 3'h0;
  logic [2:0] phase_d;
  always_comb phase_d = run ? phase_q + 3'h1 : 3'h0;
  always_ff @(posedge clk) phase_q <= phase_d;
  // additive on channel A, wild on its own pin
  // wild keeps the undropped timing; dropA models a lost a edge
  assign wildPulse = run && !phase_q[2];
  assign quadA = wildPulse && !dropA;
  // b lags a by two cycles; dropB models a lost b edge
  assign quadB = run && !dropB && (phase_q[1] ^ phase_q[2]);
endmodule : fpim_meter_model

// [dv/fpim_monitor_assertions.sv]
`timescale 1ns/10ps
module fpim_monitor_assertions #(
  parameter int unsigned DI_COUNT = 4,
  parameter int unsigned QUALIFY_CYC = fpim_pkg::QUALIFY_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire fpim_pkg::fpim_cfg_t cfg,
  input wire logic [DI_COUNT-1:0] digitalInput,
  input wire fpim_pkg::fpim_flow_t flow,
  input wire fpim_pkg::fpim_check_t check,
  input wire logic [DI_COUNT-1:0] digitalQualified,
  input wire logic phaseErrPulse,
  input wire logic missingPulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ------------
  // stable run
  // ------------
  logic lastIn_q;
  logic [31:0] runLen_q;
  logic [31:0] runLen_d;
  always_comb runLen_d = (digitalInput[0] == lastIn_q) ? runLen_q + 1 : '0;
  always_ff @(posedge clk) begin
    lastIn_q <= digitalInput[0];
    runLen_q <= rst ? '0 : runLen_d;
  end
  property p_hw_set;
    cfg.quadEnable && check.batchErrors > cfg.errThresh |-> check.hwError;
  endproperty
  a_hw_set: assert property (p_hw_set)
    else $error("hw error not set");
  property p_hw_hold;
    check.hwError && cfg.quadEnable |=> check.hwError;
  endproperty
  a_hw_hold: assert property (p_hw_hold)
    else $error("hw error lost");
  property p_quad_off;
    !cfg.quadEnable |=> !check.hwError && check.batchErrors == 8'h00;
  endproperty
  a_quad_off: assert property (p_quad_off)
    else $error("check active");
  property p_below;
    check.belowCutoff && $past(check.belowCutoff)
      |-> check.batchErrors <= $past(check.batchErrors);
  endproperty
  a_below: assert property (p_below)
    else $error("counted below cut");
  property p_step;
    check.batchErrors != $past(check.batchErrors) |-> check.batchErrors ==
      $past(check.batchErrors) + 8'h01 || check.batchErrors == 8'h00;
  endproperty
  a_step: assert property (p_step)
    else $error("error count jump");
  property p_cause;
    check.batchErrors > $past(check.batchErrors) |->
      missingPulse || phaseErrPulse || $past(missingPulse || phaseErrPulse);
  endproperty
  a_cause: assert property (p_cause)
    else $error("count without event");
  property p_pulse;
    missingPulse |=> !missingPulse;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("missing pulse long");
  property p_qual;
    $changed(digitalQualified[0]) |-> runLen_q + 2 >= QUALIFY_CYC;
  endproperty
  a_qual: assert property (p_qual)
    else $error("input not stable");
  property p_count;
    $changed(flow.wildCount) |-> flow.wildCount == $past(flow.wildCount) + 1;
  endproperty
  a_count: assert property (p_count)
    else $error("wild count jump");
  c_hw: cover property ($rose(check.hwError));
  c_miss: cover property (missingPulse && check.belowCutoff);
  c_qual: cover property ($rose(digitalQualified[0]));
  c_phase: cover property (phaseErrPulse && !check.belowCutoff);
endmodule : fpim_monitor_assertions

// [dv/fpim_monitor_bench.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin \
  nMismatch++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module fpim_monitor_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic dropA = 1'b0;
  logic dropB = 1'b0;
  logic quadA, quadB, wildPulse, phaseErrPulse, missingPulse;
  fpim_pkg::fpim_cfg_t cfg = '0;
  logic [3:0] digitalInput = 4'h0;
  logic [3:0] digitalQualified;
  fpim_pkg::fpim_flow_t flow;
  fpim_pkg::fpim_check_t check;
  int nMismatch = 0;
  int checkCount = 0;
  int cyc = 0;
  int misses = 0;
  int phases = 0;
  initial forever #50 clk = ~clk;
  fpim_monitor #(.DI_COUNT(4), .QUALIFY_CYC(20), .SEC_CYC(1000))
    fpim_monitor_inst (.clk, .rst, .cfg, .quadA, .quadB, .wildPulse,
    .digitalInput, .flow, .check, .digitalQualified, .phaseErrPulse,
    .missingPulse);
  fpim_meter_model fpim_meter_model_inst (.clk, .run, .dropA, .dropB,
    .quadA, .quadB, .wildPulse);
  task automatic conclude();
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  // hang guard: whole run is about 10400 cycles
  always @(posedge clk) begin
    cyc++;
    if (missingPulse === 1'b1) misses++;
    if (phaseErrPulse === 1'b1) phases++;
    if (cyc == 20000) begin
      nMismatch++;
      conclude();
    end
  end
  task automatic restart(input fpim_pkg::fpim_cfg_t c);
    rst = 1'b1;
    run = 1'b0;
    cfg = c;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    run = 1'b1;
    misses = 0;
    phases = 0;
  endtask : restart
  task automatic skipB(input int k);
    @(posedge quadA);
    @(negedge clk) dropB = 1'b1;
    repeat (k) @(posedge quadA);
    @(negedge clk) dropB = 1'b0;
    repeat (20) @(negedge clk);
  endtask : skipB
  // drop whole a pulses only while a is low, so no pulse is cut short
  task automatic skipA(input int k);
    @(negedge wildPulse);
    @(negedge clk) dropA = 1'b1;
    repeat (k) @(negedge wildPulse);
    @(negedge clk) dropA = 1'b0;
    repeat (20) @(negedge clk);
  endtask : skipA
  task automatic testQuadError();
    restart({1'b1, 16'h0064, 8'h03, 16'h0001, 16'h0005});
    repeat (2100) @(negedge clk);
    `CHK("addLpm", 24'h00_1D4C, flow.additiveLpm)
    `CHK("wildLpm", 24'h00_05DC, flow.wildLpm)
    skipB(3);
    `CHK("errs", 8'h03, check.batchErrors)
    `CHK("hwErr", 1'b0, check.hwError)
    skipB(1);
    `CHK("hwErr", 1'b1, check.hwError)
    skipA(1);
    `CHK("misses", 4, misses)
    `CHK("phases", 1, phases)
    `CHK("errs", 8'h05, check.batchErrors)
    // run on to the 1000th a edge since reset
    while (check.batchPulses != 10'h000) @(negedge clk);
    `CHK("errs", 8'h00, check.batchErrors)
    `CHK("hwErr", 1'b1, check.hwError)
    `CHK("addCnt", 32'h0000_03E8, flow.additiveCount)
    `CHK("wildCnt", 32'h0000_03E9, flow.wildCount)
  endtask : testQuadError
  task automatic testCutoff(input logic quad, input logic [15:0] hz);
    restart({quad, hz, 8'h03, 16'h0001, 16'h0001});
    repeat (1100) @(negedge clk);
    skipB(5);
    `CHK("misses", quad ? 5 : 0, misses)
    `CHK("errs", 8'h00, check.batchErrors)
    `CHK("hwErr", 1'b0, check.hwError)
  endtask : testCutoff
  task automatic testQualify();
    digitalInput = 4'h1;
    repeat (10) @(negedge clk);
    digitalInput = 4'h0;
    repeat (30) @(negedge clk);
    `CHK("glitch", 4'h0, digitalQualified)
    digitalInput = 4'h5;
    repeat (15) @(negedge clk);
    `CHK("early", 4'h0, digitalQualified)
    repeat (15) @(negedge clk);
    `CHK("qual", 4'h5, digitalQualified)
  endtask : testQualify
  initial begin
    testQuadError();
    testQualify();
    testCutoff(1'b1, 16'h00C8);
    `CHK("below", 1'b1, check.belowCutoff)
    testCutoff(1'b0, 16'h0064);
    conclude();
  end
endmodule : fpim_monitor_bench
bind fpim_monitor fpim_monitor_assertions #(.DI_COUNT(DI_COUNT),
  .QUALIFY_CYC(QUALIFY_CYC)) fpim_monitor_assertions_inst (.clk, .rst,
  .cfg, .digitalInput, .flow, .check, .digitalQualified, .phaseErrPulse,
  .missingPulse);
